// *** wkt_auto_wakeup.sv ***
/*
  Timed halt wake-up unit: APB registers, power mode controller for the
  halt instruction, RC oscillator control, measurement routing and main
  oscillator stabilisation.
  Assumes the CPU pulses halt_exec for one cycle and that pclk keeps running
  in this model while the chip is notionally halted.
*/
// Design decision made here: the APB slave port.
module wkt_auto_wakeup (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wkt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic oscillator_irq_enable,
  input wire logic watchdog_active,
  input wire logic watchdog_halt_option,
  input wire logic stab_long_sel,
  input wire logic irq_pending,
  input wire logic halt_exit_irq,
  input wire logic realtime_irq,
  input wire logic rc_osc_clk,
  input wire logic rc_osc_ready,
  output logic rc_osc_enable,
  output logic timer_capture_input_one,
  output logic main_osc_enable,
  output logic periph_clk_enable,
  output logic realtime_counter_run,
  output logic wakeup_irq,
  output logic mask_force,
  output logic [1:0] interrupt_mask_level,
  output logic watchdog_reset_req,
  output logic cpu_resume
);

  // ****************************************************************
  // Register bus
  // ****************************************************************

  logic enable_r, enable_nxt;
  logic measure_r, measure_nxt;
  logic flag_r, flag_nxt;
  logic [7:0] presc_r, presc_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic setup_phase;
  logic access_done;
  logic hit_csr;
  logic hit_presc;
  logic wake_event;

  wkt_cnt_if cnt_bus ();

  // Address decode.
  function automatic logic [1:0] decode(input logic [wkt_pkg::ADDR_W-1:0] a);
    decode = {a == wkt_pkg::PRESC_ADDR, a == wkt_pkg::CSR_ADDR};
  endfunction

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable;
  assign {hit_presc, hit_csr} = decode(paddr);
  assign wake_event = cnt_bus.expired;

  // Read data and the error answer are prepared in the setup cycle, so
  // every access completes in its first access cycle.
  always_comb
  begin
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    if (setup_phase)
    begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = !(hit_csr || hit_presc);
      if (hit_csr)
      begin
        rdata_nxt[wkt_pkg::CSR_ENABLE_BIT] = enable_r;
        rdata_nxt[wkt_pkg::CSR_MEASURE_BIT] = measure_r;
        rdata_nxt[wkt_pkg::CSR_FLAG_BIT] = flag_r;
      end
      if (hit_presc)
      begin
        rdata_nxt[7:0] = presc_r;
      end
    end
  end

  // Software-owned bits, the prescaler and the hardware wake flag.
  always_comb
  begin
    enable_nxt = enable_r;
    measure_nxt = measure_r;
    presc_nxt = presc_r;
    flag_nxt = flag_r;
    if (access_done && pwrite && hit_csr)
    begin
      enable_nxt = pwdata[wkt_pkg::CSR_ENABLE_BIT];
      measure_nxt = pwdata[wkt_pkg::CSR_MEASURE_BIT];
    end
    if (access_done && pwrite && hit_presc && pwdata[7:0] != wkt_pkg::PRESC_FORBIDDEN)
    begin
      presc_nxt = pwdata[7:0];
    end
    if (access_done && !pwrite && hit_csr)
    begin
      flag_nxt = 1'b0;
    end
    // A wake event in the clearing cycle is kept.
    if (wake_event)
    begin
      flag_nxt = 1'b1;
    end
  end

  // Register bank.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r <= wkt_pkg::CSR_RESET[wkt_pkg::CSR_ENABLE_BIT];
      measure_r <= wkt_pkg::CSR_RESET[wkt_pkg::CSR_MEASURE_BIT];
      flag_r <= wkt_pkg::CSR_RESET[wkt_pkg::CSR_FLAG_BIT];
      presc_r <= wkt_pkg::PRESC_RESET;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else
    begin
      enable_r <= enable_nxt;
      measure_r <= measure_nxt;
      flag_r <= flag_nxt;
      presc_r <= presc_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_r;
  assign pslverr = access_done && err_r;
  assign wakeup_irq = flag_r;

  // ****************************************************************
  // Power mode controller
  // ****************************************************************

  wkt_pkg::wkt_state_e state_r, state_nxt;
  logic [wkt_pkg::STAB_W-1:0] stab_r, stab_nxt;
  logic stab_long_r, stab_long_nxt;
  logic mask_force_r, mask_force_nxt;
  logic wdg_rst_r, wdg_rst_nxt;
  logic resume_r, resume_nxt;
  logic restart_nxt;
  logic restart_r;

  // Mode transitions for the halt instruction and its exits.
  always_comb
  begin
    state_nxt = state_r;
    stab_nxt = stab_r;
    stab_long_nxt = stab_long_r;
    mask_force_nxt = 1'b0;
    wdg_rst_nxt = 1'b0;
    resume_nxt = 1'b0;
    restart_nxt = 1'b0;
    unique case (state_r)
      wkt_pkg::ST_RUN:
      begin
        if (halt_exec)
        begin
          if (oscillator_irq_enable)
          begin
            state_nxt = wkt_pkg::ST_ACTIVE_HALT;
            mask_force_nxt = 1'b1;
          end
          else if (watchdog_active && !watchdog_halt_option)
          begin
            wdg_rst_nxt = 1'b1;
          end
          else if (enable_r)
          begin
            state_nxt = wkt_pkg::ST_TIMED_HALT;
            mask_force_nxt = 1'b1;
            restart_nxt = 1'b1;
          end
          else
          begin
            state_nxt = wkt_pkg::ST_HALT;
            mask_force_nxt = 1'b1;
          end
        end
      end
      wkt_pkg::ST_HALT:
      begin
        if (halt_exit_irq || irq_pending)
        begin
          state_nxt = wkt_pkg::ST_STABILISE;
        end
      end
      wkt_pkg::ST_TIMED_HALT:
      begin
        // Pending interrupts leave at once once the mask is opened.
        if (wake_event || halt_exit_irq || irq_pending)
        begin
          state_nxt = wkt_pkg::ST_STABILISE;
        end
      end
      wkt_pkg::ST_ACTIVE_HALT:
      begin
        // The main oscillator never stopped, so no stabilisation follows.
        if (realtime_irq || halt_exit_irq || irq_pending)
        begin
          state_nxt = wkt_pkg::ST_RUN;
          resume_nxt = 1'b1;
        end
      end
      wkt_pkg::ST_STABILISE:
      begin
        if (stab_r == (stab_long_r ? wkt_pkg::STAB_LONG_LAST : wkt_pkg::STAB_SHORT_LAST))
        begin
          state_nxt = wkt_pkg::ST_RUN;
          resume_nxt = 1'b1;
        end
        else
        begin
          stab_nxt = stab_r + 1'b1;
        end
      end
      default:
      begin
        state_nxt = wkt_pkg::ST_RUN;
      end
    endcase
    if (state_nxt == wkt_pkg::ST_STABILISE && state_r != wkt_pkg::ST_STABILISE)
    begin
      stab_nxt = '0;
      stab_long_nxt = stab_long_sel;
    end
  end

  // Mode registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= wkt_pkg::ST_RUN;
      stab_r <= '0;
      stab_long_r <= 1'b0;
      mask_force_r <= 1'b0;
      wdg_rst_r <= 1'b0;
      resume_r <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      stab_r <= stab_nxt;
      stab_long_r <= stab_long_nxt;
      mask_force_r <= mask_force_nxt;
      wdg_rst_r <= wdg_rst_nxt;
      resume_r <= resume_nxt;
      restart_r <= restart_nxt;
    end
  end

  assign mask_force = mask_force_r;
  assign interrupt_mask_level = wkt_pkg::HALT_MASK_LEVEL;
  assign watchdog_reset_req = wdg_rst_r;
  assign cpu_resume = resume_r;

  // ****************************************************************
  // Clock and oscillator control
  // ****************************************************************

  logic rc_en_r, rc_en_nxt;
  logic cap_r, cap_nxt;
  logic main_osc_r, main_osc_nxt;
  logic periph_r, periph_nxt;
  logic rtc_r, rtc_nxt;

  // Oscillator enables follow the next mode so they switch with it.
  always_comb
  begin
    rc_en_nxt = measure_r || state_nxt == wkt_pkg::ST_TIMED_HALT;
    cap_nxt = measure_r && rc_osc_clk;
    main_osc_nxt = state_nxt == wkt_pkg::ST_RUN || state_nxt == wkt_pkg::ST_STABILISE
                   || state_nxt == wkt_pkg::ST_ACTIVE_HALT;
    periph_nxt = state_nxt == wkt_pkg::ST_RUN;
    rtc_nxt = state_nxt != wkt_pkg::ST_HALT && state_nxt != wkt_pkg::ST_TIMED_HALT
              && state_nxt != wkt_pkg::ST_STABILISE;
  end

  // Oscillator control registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_en_r <= 1'b0;
      cap_r <= 1'b0;
      main_osc_r <= 1'b1;
      periph_r <= 1'b1;
      rtc_r <= 1'b1;
    end
    else
    begin
      rc_en_r <= rc_en_nxt;
      cap_r <= cap_nxt;
      main_osc_r <= main_osc_nxt;
      periph_r <= periph_nxt;
      rtc_r <= rtc_nxt;
    end
  end

  assign rc_osc_enable = rc_en_r;
  assign timer_capture_input_one = cap_r;
  assign main_osc_enable = main_osc_r;
  assign periph_clk_enable = periph_r;
  assign realtime_counter_run = rtc_r;

  // ****************************************************************
  // Delay counter
  // ****************************************************************

  // Counting waits for the RC start-up, which adds its time to the delay.
  assign cnt_bus.restart = restart_r;
  assign cnt_bus.count_en = state_r == wkt_pkg::ST_TIMED_HALT && rc_osc_ready;
  assign cnt_bus.rc_level = rc_osc_clk;
  assign cnt_bus.presc = presc_r;

  wkt_delay_counter u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .bus(cnt_bus)
  );

endmodule

// *** wkt_pkg.sv ***
/*
  Package for the timed halt wake-up block: register indices, byte addresses,
  field positions, reset values, divider figures and the mode encoding.
  Assumes a 32-bit APB bus with one aligned word per register.
*/
package wkt_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are register indices; the byte address is four times that.
  localparam logic [7:0] CSR_INDEX = 8'h2b;
  localparam logic [7:0] PRESC_INDEX = 8'h2c;
  localparam logic [9:0] CSR_ADDR = {CSR_INDEX, 2'b00};
  localparam logic [9:0] PRESC_ADDR = {PRESC_INDEX, 2'b00};
  localparam int ADDR_W = 10;

  // Control/status fields.
  localparam int CSR_ENABLE_BIT = 0;
  localparam int CSR_MEASURE_BIT = 1;
  localparam int CSR_FLAG_BIT = 2;

  // Reset values and the forbidden prescaler value.
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] PRESC_RESET = 8'hff;
  localparam logic [7:0] PRESC_FORBIDDEN = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Fixed divider ahead of the prescaler, in RC periods.
  localparam int FIXED_DIV = 64;
  localparam int FIXED_DIV_W = $clog2(FIXED_DIV);
  localparam logic [FIXED_DIV_W-1:0] FIXED_DIV_LAST = FIXED_DIV_W'(FIXED_DIV - 1);
  // Main oscillator stabilisation, in CPU cycles.
  localparam int STAB_SHORT_CYC = 256;
  localparam int STAB_LONG_CYC = 4096;
  localparam int STAB_W = 12;
  localparam logic [STAB_W-1:0] STAB_SHORT_LAST = STAB_W'(STAB_SHORT_CYC - 1);
  localparam logic [STAB_W-1:0] STAB_LONG_LAST = STAB_W'(STAB_LONG_CYC - 1);

  // Interrupt mask level forced on halt entry.
  localparam logic [1:0] HALT_MASK_LEVEL = 2'b10;

  // ****************************************************************
  // Power mode states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_HALT = 5'b00010,
    ST_ACTIVE_HALT = 5'b00100,
    ST_TIMED_HALT = 5'b01000,
    ST_STABILISE = 5'b10000
  } wkt_state_e;

endpackage

// *** wkt_cnt_if.sv ***
/*
  Interface joining the mode controller to the wake-up delay counter.
  Assumes both ends run on the same clock.
*/
interface wkt_cnt_if;
  logic restart;
  logic count_en;
  logic rc_level;
  logic [7:0] presc;
  logic expired;

  modport ctrl (output restart, output count_en, output rc_level, output presc,
                input expired);
  modport cnt (input restart, input count_en, input rc_level, input presc,
               output expired);
endinterface

// *** wkt_delay_counter.sv ***
/*
  Wake-up delay counter: counts rising edges of the RC oscillator through a
  fixed divide-by-64 stage and the sampled prescaler factor.
  Assumes the RC level is synchronous to pclk and at least two pclk periods
  per phase.
*/
module wkt_delay_counter (
  input wire logic pclk,
  input wire logic presetn,
  wkt_cnt_if.cnt bus
);

  logic rc_prev_r, rc_prev_nxt;
  logic [wkt_pkg::FIXED_DIV_W-1:0] div_r, div_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic [7:0] factor_r, factor_nxt;
  logic expired_r, expired_nxt;

  assign bus.expired = expired_r;

  // Next-state: restart samples the factor and clears both stages.
  always_comb
  begin
    rc_prev_nxt = bus.rc_level;
    div_nxt = div_r;
    pre_nxt = pre_r;
    factor_nxt = factor_r;
    expired_nxt = 1'b0;
    if (bus.restart)
    begin
      div_nxt = '0;
      pre_nxt = '0;
      factor_nxt = bus.presc;
    end
    else if (bus.count_en && bus.rc_level && !rc_prev_r)
    begin
      div_nxt = div_r + 1'b1;
      if (div_r == wkt_pkg::FIXED_DIV_LAST)
      begin
        pre_nxt = pre_r + 8'h01;
        // Delay is 64 times the factor in RC periods.
        if (pre_r + 8'h01 == factor_r)
        begin
          expired_nxt = 1'b1;
          pre_nxt = '0;
        end
      end
    end
  end

  // Registers of the counter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_prev_r <= 1'b0;
      div_r <= '0;
      pre_r <= '0;
      factor_r <= wkt_pkg::PRESC_RESET;
      expired_r <= 1'b0;
    end
    else
    begin
      rc_prev_r <= rc_prev_nxt;
      div_r <= div_nxt;
      pre_r <= pre_nxt;
      factor_r <= factor_nxt;
      expired_r <= expired_nxt;
    end
  end

endmodule

// *** wkt_auto_wakeup_props.sv ***
/*
  Checker for the timed halt wake-up block, bound to its top module.
  Assumes the short 256-cycle stabilisation whenever stab_long_sel is low.
*/
module wkt_auto_wakeup_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wkt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic halt_exec,
  input wire logic oscillator_irq_enable,
  input wire logic watchdog_active,
  input wire logic watchdog_halt_option,
  input wire logic stab_long_sel,
  input wire logic rc_osc_enable,
  input wire logic timer_capture_input_one,
  input wire logic main_osc_enable,
  input wire logic periph_clk_enable,
  input wire logic realtime_counter_run,
  input wire logic wakeup_irq,
  input wire logic mask_force,
  input wire logic [1:0] interrupt_mask_level,
  input wire logic watchdog_reset_req,
  input wire logic cpu_resume
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic csr;
  logic hrun;
  logic wdg;
  // Access phase, control register decode, halt in run, watchdog option.
  assign acc = psel && penable;
  assign csr = paddr == wkt_pkg::CSR_ADDR;
  assign hrun = halt_exec && periph_clk_enable;
  assign wdg = watchdog_active && !watchdog_halt_option;
  AST_MASK_LEVEL: assert property (interrupt_mask_level == 2'b10)
    else $error("mask level is not 10b");
  AST_SLVERR: assert property (acc |-> pslverr == !(csr || paddr == wkt_pkg::PRESC_ADDR))
    else $error("error response on wrong address");
  AST_RD_ZERO: assert property (acc && !pwrite |-> prdata[31:8] == 0 && !(csr && prdata[7:3] != 0))
    else $error("reserved read bits not zero");
  // Read data is loaded at the setup edge, so it shows the flag as it stood then.
  AST_FLAG_READ: assert property (acc && !pwrite && csr |-> prdata[2] == $past(wakeup_irq))
    else $error("flag bit differs from interrupt");
  AST_READ_CLEAR: assert property (acc && !pwrite && csr && wakeup_irq && periph_clk_enable |=> !wakeup_irq)
    else $error("read did not clear flag");
  AST_TIMED: assert property (hrun && !oscillator_irq_enable && !wdg |=> !main_osc_enable && !periph_clk_enable)
    else $error("halt did not stop clocks");
  AST_WDG: assert property (hrun && !oscillator_irq_enable && wdg |=> watchdog_reset_req && periph_clk_enable)
    else $error("no watchdog reset on halt");
  AST_ACTIVE: assert property (hrun && oscillator_irq_enable |=> main_osc_enable && realtime_counter_run && !periph_clk_enable)
    else $error("active halt not entered");
  AST_MASK_PULSE: assert property (hrun && !(wdg && !oscillator_irq_enable) |-> ##[1:2] mask_force)
    else $error("mask not forced on halt");
  AST_HALT_CLK: assert property (!main_osc_enable |-> !periph_clk_enable && !realtime_counter_run)
    else $error("clocks run while halted");
  AST_STAB: assert property ($rose(wakeup_irq) && !stab_long_sel |-> ##[254:258] cpu_resume)
    else $error("stabilisation length wrong");
  AST_CAP_IDLE: assert property (!rc_osc_enable [*2] |-> !timer_capture_input_one)
    else $error("capture active with oscillator off");
endmodule
bind wkt_auto_wakeup wkt_auto_wakeup_props i_wkt_auto_wakeup_props (.*);

// *** wkt_rc_model.sv ***
/*
  Model of the wake-up RC oscillator: period of eight pclk cycles.
  Assumes rc_osc_enable from the block; the clock stands at 0 when off.
*/
module wkt_rc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rc_osc_enable,
  output logic rc_osc_clk,
  output logic rc_osc_ready,
  output int rc_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_r;
  // Phase, start-up and tally of rising edges seen after start-up.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r <= 3'h0;
      rc_osc_clk <= 1'b0;
      rc_osc_ready <= 1'b0;
      rc_edges <= 0;
    end
    else if (!rc_osc_enable)
    begin
      ph_r <= 3'h0;
      rc_osc_clk <= 1'b0;
      rc_osc_ready <= 1'b0;
    end
    else
    begin
      ph_r <= ph_r + 3'h1;
      rc_osc_clk <= ph_r[2];
      if (ph_r == 3'h1)
        rc_osc_ready <= 1'b1;
      if (ph_r == 3'h4 && rc_osc_ready)
        rc_edges <= rc_edges + 1;
    end
  end
endmodule

// *** wkt_auto_wakeup_tb_top.sv ***
/*
  Testbench for the timed halt wake-up block over APB.
  Assumes zero or more wait states and the RC model as oscillator.
*/
module wkt_auto_wakeup_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic halt_exec, oscillator_irq_enable, watchdog_active, watchdog_halt_option;
  logic stab_long_sel, irq_pending, halt_exit_irq, realtime_irq;
  logic rc_osc_clk, rc_osc_ready, rc_osc_enable, timer_capture_input_one, c0;
  logic main_osc_enable, periph_clk_enable, realtime_counter_run, wakeup_irq;
  logic mask_force, watchdog_reset_req, cpu_resume;
  logic [1:0] interrupt_mask_level;
  int rc_edges, fail_count, checks_done, n, base;
  wkt_auto_wakeup i_wkt_auto_wakeup (.*);
  wkt_rc_model i_wkt_rc_model (.*);
  // Clock of 100 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic ee);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, ee});
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      fail_count++;
      $display("BAD %0t no ready answer", $time);
      summarize();
    end
  endtask
  // Waits at falling edges for wake flag (0), resume (1) or watchdog (2).
  task wait_sig(input int which, input int lim);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (hit !== 1'b1 && n < lim)
    begin
      @(negedge pclk);
      n++;
      hit = which == 0 ? wakeup_irq : which == 1 ? cpu_resume : watchdog_reset_req;
    end
    if (hit !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      summarize();
    end
  endtask
  task halt();
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    @(negedge pclk);
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {halt_exec, oscillator_irq_enable, watchdog_active, stab_long_sel} = '0;
    {irq_pending, halt_exit_irq, realtime_irq} = '0;
    watchdog_halt_option = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, wkt_pkg::CSR_ADDR, 0, 0);
    chk(r, 32'h0);
    apb(0, wkt_pkg::PRESC_ADDR, 0, 0);
    chk(r, 32'hff);
    apb(0, 10'h000, 0, 1);
    chk(r, 32'h0);
    apb(1, wkt_pkg::CSR_ADDR, 32'hff, 0);
    apb(0, wkt_pkg::CSR_ADDR, 0, 0);
    chk(r, 32'h3);
    apb(1, wkt_pkg::PRESC_ADDR, 32'h0, 0);
    apb(0, wkt_pkg::PRESC_ADDR, 0, 0);
    chk(r, 32'hff);
    apb(1, wkt_pkg::PRESC_ADDR, 32'h2, 0);
    apb(0, wkt_pkg::PRESC_ADDR, 0, 0);
    chk(r, 32'h2);
    repeat (8) @(negedge pclk);
    chk({31'h0, rc_osc_enable}, 32'h1);
    c0 = timer_capture_input_one;
    repeat (4) @(negedge pclk);
    chk({31'h0, timer_capture_input_one}, {31'h0, ~c0});
    apb(1, wkt_pkg::CSR_ADDR, 32'h1, 0);
    repeat (2) @(negedge pclk);
    chk({30'h0, rc_osc_enable, timer_capture_input_one}, 32'h0);
    $display("register test done");
    base = rc_edges;
    halt();
    chk({29'h0, main_osc_enable, periph_clk_enable, rc_osc_enable}, 32'h1);
    wait_sig(0, 2000);
    chk(32'(rc_edges - base), 32'h80);
    chk({31'h0, main_osc_enable}, 32'h1);
    wait_sig(1, 300);
    chk({31'h0, n >= 255 && n <= 257}, 32'h1);
    apb(0, wkt_pkg::CSR_ADDR, 0, 0);
    chk(r, 32'h5);
    apb(0, wkt_pkg::CSR_ADDR, 0, 0);
    chk({r[31:0]}, 32'h1);
    chk({31'h0, wakeup_irq}, 32'h0);
    $display("timed halt test done");
    @(posedge pclk);
    irq_pending <= 1'b1;
    halt();
    wait_sig(1, 300);
    chk({31'h0, wakeup_irq}, 32'h0);
    @(posedge pclk);
    irq_pending <= 1'b0;
    oscillator_irq_enable <= 1'b1;
    halt();
    chk({29'h0, main_osc_enable, realtime_counter_run, periph_clk_enable}, 32'h6);
    @(posedge pclk);
    realtime_irq <= 1'b1;
    wait_sig(1, 10);
    @(posedge pclk);
    realtime_irq <= 1'b0;
    oscillator_irq_enable <= 1'b0;
    $display("pending and active halt test done");
    apb(1, wkt_pkg::CSR_ADDR, 32'h0, 0);
    halt();
    chk({30'h0, main_osc_enable, rc_osc_enable}, 32'h0);
    @(posedge pclk);
    halt_exit_irq <= 1'b1;
    wait_sig(1, 300);
    @(posedge pclk);
    halt_exit_irq <= 1'b0;
    watchdog_active <= 1'b1;
    watchdog_halt_option <= 1'b0;
    halt();
    // The watchdog request is a one-cycle pulse, so it is looked at while it stands.
    chk({31'h0, watchdog_reset_req}, 32'h1);
    chk({31'h0, periph_clk_enable}, 32'h1);
    $display("plain halt and watchdog test done");
    // A reset in the middle of a timed halt must bring the block back to run.
    @(posedge pclk);
    watchdog_active <= 1'b0;
    apb(1, wkt_pkg::CSR_ADDR, 32'h1, 0);
    halt();
    chk({31'h0, rc_osc_enable}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({29'h0, main_osc_enable, periph_clk_enable, rc_osc_enable}, 32'h6);
    apb(0, wkt_pkg::CSR_ADDR, 0, 0);
    chk(r, 32'h0);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
